// ### logic/serial_8b10b_char_codec.sv
// Top of the character codec: DWORD serializer, deserializer and error counter.
// How it works
// R1: K28.3 opens every non-sync primitive, by disparity.
// R2: K28.5 opens only the lane-sync primitive.
// R3: Only two control characters, only at byte 0.
// R4: Primitive characters follow ordinary disparity rules.
// R5: A control character inverts running disparity.
// R6: Lane-sync primitive leaves disparity unchanged.
// R7: Bits leave as a b c d e i f g h j.
// R8: DWORD bytes leave from byte 0 to 3.
// R9: Frame DWORDs leave in ascending order.
// R10: Wider paths must match byte-serial result.
// R11: Decode only from the current disparity column.
// R12: Unknown character is flagged as code violation.
// R13: Disparity updates even on violating characters.
// R14: Disparity is carried per six and four bit sub-block.
// R15: Same non-neutral sign twice is invalid.
// R16: Errors are counted for link quality.
// R17: Primitive is control byte plus three characters.
// R18: Decoded bytes carry a control or data flag.
`timescale 1ns/1ps
module serial_8b10b_char_codec (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [31:0] tx_dword,
    input wire logic tx_prim,
    input wire logic tx_sync,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic link_clk,
    output logic ser_tx,
    input wire logic ser_rx,
    output logic [7:0] rx_byte,
    output logic rx_ctrl,
    output logic [1:0] rx_lane,
    output logic rx_valid,
    output logic rx_viol,
    output logic rx_misplaced,
    output logic [char_codec_pkg::ERR_W-1:0] err_count,
    input wire logic err_clr
);
    import char_codec_pkg::*;

    function automatic logic is_ctrl_code(input logic [9:0] c);
        return (c == K283_NEG) || (c == K283_POS) || (c == K285_NEG) || (c == K285_POS);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Link clock and receive pin sampling.

    logic [SYNC_N-1:0] lk_sync_r;
    logic [SYNC_N-1:0] rx_sync_r;
    logic lk_lvl_r;
    logic rx_lvl_r;
    logic lk_agree;
    logic lk_rise;
    logic rx_bit;

    assign lk_agree = lk_sync_r[1] == lk_sync_r[2];
    assign lk_rise = lk_agree && lk_sync_r[2] && !lk_lvl_r;
    assign rx_bit = (rx_sync_r[1] == rx_sync_r[2]) ? rx_sync_r[2] : rx_lvl_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lk_sync_r <= '0;
            rx_sync_r <= '0;
            lk_lvl_r <= 1'b0;
            rx_lvl_r <= 1'b0;
        end else begin
            lk_sync_r <= {lk_sync_r[SYNC_N-2:0], link_clk};
            rx_sync_r <= {rx_sync_r[SYNC_N-2:0], ser_rx};
            if (lk_agree) begin
                lk_lvl_r <= lk_sync_r[2];
            end
            rx_lvl_r <= rx_bit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit DWORD holding and byte selection.

    logic [31:0] hold_r;
    logic prim_r;
    logic sync_r;
    logic has_r;
    logic [1:0] idx_r;
    logic busy_r;
    logic enc_load;
    logic enc_k;
    logic [7:0] enc_byte;
    logic [9:0] enc_code;
    logic enc_rd;

    assign tx_ready = !has_r;
    assign enc_load = has_r && !busy_r;
    assign enc_k = prim_r && (idx_r == 2'h0); // R3 R17
    assign enc_byte = hold_r[{idx_r, 3'h0} +: 8]; // R8

    // DWORDs are sent in the order they are taken, so the link layer sets frame order.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            hold_r <= 32'h0000_0000;
            prim_r <= 1'b0;
            sync_r <= 1'b0;
            has_r <= 1'b0;
            idx_r <= 2'h0;
        end else begin
            if (tx_valid && tx_ready) begin // R9
                hold_r <= tx_dword;
                prim_r <= tx_prim;
                sync_r <= tx_sync && tx_prim;
                has_r <= 1'b1;
            end else if (enc_load) begin
                idx_r <= 2'(idx_r + 2'h1); // R8
                if (idx_r == BYTE_LAST) begin
                    has_r <= 1'b0;
                end
            end
        end
    end

    char_encoder u_enc (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .load(enc_load),
        .byte_in(enc_byte),
        .is_ctrl(enc_k),
        .is_comma(sync_r),
        .code(enc_code),
        .rd(enc_rd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Transmit serializer, one character at a time on link clock rises.

    logic ld_shift_r;
    logic [1:0] ld_idx_r;
    logic ld_k_r;
    logic ld_sync_r;
    logic ld_prim_r;
    logic align_rd_r;
    logic active_r;
    logic [9:0] shift_r;
    logic [3:0] bit_cnt_r;
    logic ser_tx_r;

    assign ser_tx = ser_tx_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            ld_shift_r <= 1'b0;
            ld_idx_r <= 2'h0;
            ld_k_r <= 1'b0;
            ld_sync_r <= 1'b0;
            ld_prim_r <= 1'b0;
            align_rd_r <= RD_INIT;
        end else begin
            ld_shift_r <= enc_load;
            if (enc_load) begin
                ld_idx_r <= idx_r;
                ld_k_r <= enc_k;
                ld_sync_r <= sync_r;
                ld_prim_r <= prim_r;
                if (enc_k && sync_r) begin
                    align_rd_r <= enc_rd;
                end
            end
        end
    end

    // In a gap between DWORDs the line holds its last bit; no fill character is sent.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            busy_r <= 1'b0;
            active_r <= 1'b0;
            shift_r <= 10'h000;
            bit_cnt_r <= 4'h0;
            ser_tx_r <= 1'b0;
        end else begin
            if (enc_load) begin
                busy_r <= 1'b1;
            end else if (lk_rise && active_r && (bit_cnt_r == BIT_LAST)) begin
                busy_r <= 1'b0;
            end
            if (ld_shift_r) begin
                shift_r <= enc_code;
                active_r <= 1'b1;
                bit_cnt_r <= 4'h0;
            end else if (lk_rise && active_r) begin
                ser_tx_r <= shift_r[9]; // R7 R10
                shift_r <= {shift_r[8:0], 1'b0};
                bit_cnt_r <= 4'(bit_cnt_r + 4'h1);
                if (bit_cnt_r == BIT_LAST) begin
                    active_r <= 1'b0;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Receive deserializer with comma alignment.

    logic [9:0] rx_sh_r;
    logic [9:0] rx_sh_nxt;
    logic [3:0] rx_cnt_r;
    logic rx_lock_r;
    logic dec_go_r;
    logic [9:0] dec_code_r;
    logic comma;
    logic dec_rd;

    assign rx_sh_nxt = {rx_sh_r[8:0], rx_bit};
    assign comma = (rx_sh_nxt == K285_NEG) || (rx_sh_nxt == K285_POS);

    // A comma anywhere realigns; no other pattern can move the character boundary.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            rx_sh_r <= 10'h000;
            rx_cnt_r <= 4'h0;
            rx_lock_r <= 1'b0;
            dec_go_r <= 1'b0;
            dec_code_r <= 10'h000;
        end else begin
            dec_go_r <= 1'b0;
            if (lk_rise) begin
                rx_sh_r <= rx_sh_nxt;
                if (comma || (rx_lock_r && (rx_cnt_r == BIT_LAST))) begin
                    rx_lock_r <= 1'b1;
                    rx_cnt_r <= 4'h0;
                    dec_go_r <= 1'b1;
                    dec_code_r <= rx_sh_nxt;
                end else begin
                    rx_cnt_r <= 4'(rx_cnt_r + 4'h1);
                end
            end
        end
    end

    char_decoder u_dec (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .go(dec_go_r),
        .code(dec_code_r),
        .data(rx_byte),
        .ctrl(rx_ctrl),
        .viol(rx_viol),
        .valid(rx_valid),
        .rd(dec_rd)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Byte lane tracking and error counting.

    logic [1:0] lane_r;
    logic seen_r;
    logic misplaced_r;
    logic [ERR_W-1:0] err_r;

    assign rx_lane = lane_r;
    assign rx_misplaced = misplaced_r;
    assign err_count = err_r;

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            lane_r <= BYTE_LAST;
            seen_r <= 1'b0;
            misplaced_r <= 1'b0;
        end else if (dec_go_r) begin
            if (is_ctrl_code(dec_code_r)) begin
                lane_r <= 2'h0;
                seen_r <= 1'b1;
                misplaced_r <= seen_r && (lane_r != BYTE_LAST); // R3
            end else begin
                lane_r <= 2'(lane_r + 2'h1);
                misplaced_r <= 1'b0;
            end
        end
    end

    // A new error in the clearing cycle is kept, so no event is lost.
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            err_r <= '0;
        end else if (rx_valid && (rx_viol || rx_misplaced)) begin
            if (err_clr) begin
                err_r <= 16'h0001; // R16
            end else if (err_r != ERR_MAX) begin
                err_r <= err_r + 16'h0001; // R16
            end
        end else if (err_clr) begin
            err_r <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks.

    a_k283_code: assert property (@(posedge core_clk) disable iff (!rst_n) // R1
        ld_shift_r && ld_k_r && !ld_sync_r |->
            enc_code == ($past(enc_rd) ? K283_POS : K283_NEG))
        else $error("wrong first-primitive control code");

    a_k285_code: assert property (@(posedge core_clk) disable iff (!rst_n) // R2
        ld_shift_r && ld_k_r && ld_sync_r |->
            enc_code == ($past(enc_rd) ? K285_POS : K285_NEG))
        else $error("wrong comma control code");

    a_ctrl_place: assert property (@(posedge core_clk) disable iff (!rst_n) // R3
        ld_shift_r && ((enc_code[9:4] == K6_NEG) || (enc_code[9:4] == ~K6_NEG)) |->
            (ld_idx_r == 2'h0) && ld_prim_r)
        else $error("control character outside byte 0 of a primitive");

    a_ctrl_flip: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        ld_shift_r && ld_k_r |-> enc_rd != $past(enc_rd))
        else $error("control character kept running disparity");

    a_align_rd: assert property (@(posedge core_clk) disable iff (!rst_n) // R6
        ld_shift_r && ld_sync_r && (ld_idx_r == BYTE_LAST) |-> enc_rd == align_rd_r)
        else $error("lane-sync primitive changed running disparity");

    a_bit_first: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        lk_rise && active_r && !ld_shift_r |=> ser_tx == $past(shift_r[9]))
        else $error("serial bit not taken from the head of the character");

    a_tx_steady: assert property (@(posedge core_clk) disable iff (!rst_n) // R7
        !lk_rise |=> $stable(ser_tx))
        else $error("serial output moved without a link clock rise");

    a_rd_subblock: assert property (@(posedge core_clk) disable iff (!rst_n) // R13
        dec_go_r && ($countones(dec_code_r[3:0]) == 3) |=> dec_rd && rx_valid)
        else $error("positive last sub-block did not set disparity");

    a_rd_neg_end: assert property (@(posedge core_clk) disable iff (!rst_n) // R14
        dec_go_r && ($countones(dec_code_r[3:0]) == 1) |=> !dec_rd)
        else $error("negative last sub-block did not clear disparity");

    a_same_sign: assert property (@(posedge core_clk) disable iff (!rst_n) // R15
        dec_go_r && ($countones(dec_code_r[9:4]) == 4) && ($countones(dec_code_r[3:0]) == 3)
            |=> rx_viol)
        else $error("two positive sub-blocks not flagged");

    a_err_count: assert property (@(posedge core_clk) disable iff (!rst_n) // R16
        rx_valid && rx_viol && !err_clr && (err_count != ERR_MAX) |=>
            err_count == $past(err_count) + 16'h0001)
        else $error("violation not counted");

endmodule

// ### logic/char_codec_pkg.sv
// Package with the 8b/10b code tables, constants and coding functions.
package char_codec_pkg;

    localparam logic RD_INIT = 1'b0;
    localparam int SYNC_N = 3;
    localparam logic [3:0] BIT_LAST = 4'h9;
    localparam logic [1:0] BYTE_LAST = 2'h3;
    localparam int ERR_W = 16;
    localparam logic [ERR_W-1:0] ERR_MAX = 16'hFFFF;
    localparam logic [2:0] HALF6 = 3'h3;
    localparam logic [2:0] HALF4 = 3'h2;
    localparam logic [4:0] K_X = 5'h1C;
    localparam logic [2:0] K_Y_PRIM = 3'h3;
    localparam logic [2:0] K_Y_SYNC = 3'h5;
    localparam logic [5:0] K6_NEG = 6'h0F;
    localparam logic [9:0] K283_NEG = 10'h0F3;
    localparam logic [9:0] K283_POS = 10'h30C;
    localparam logic [9:0] K285_NEG = 10'h0FA;
    localparam logic [9:0] K285_POS = 10'h305;
    localparam logic [3:0] ALT7 = 4'h7;

    // Codes for negative running disparity, bit a in the most significant place.
    localparam logic [5:0] TAB6 [0:31] = '{
        6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
        6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
        6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
        6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B
    };
    localparam logic [3:0] TAB4 [0:7] = '{
        4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE
    };

    // Disparity at the end of one sub-block, carried into the next one.
    function automatic logic rd_step(input logic rd, input logic [5:0] c, input logic [2:0] half);
        logic [2:0] ones;
        ones = 3'($countones(c));
        if (ones > half) return 1'b1;
        if (ones < half) return 1'b0;
        return rd;
    endfunction

    function automatic logic [5:0] enc6(input logic [4:0] x, input logic rd);
        logic [5:0] c;
        c = TAB6[x];
        if (rd && (($countones(c) != 3) || (x == 5'h07))) c = ~c;
        return c;
    endfunction

    // The alternate code for y = 7 avoids a run of five equal bits across e, i, f.
    function automatic logic [3:0] enc4(input logic [2:0] y, input logic rd, input logic e,
                                        input logic i);
        logic [3:0] c;
        c = TAB4[y];
        if ((y == 3'h7) && ((!rd && e && i) || (rd && !e && !i))) c = ALT7;
        if (rd && (($countones(c) != 2) || (y == 3'h3))) c = ~c;
        return c;
    endfunction

endpackage

// ### logic/char_encoder.sv
// Registered 8b/10b character encoder that keeps the transmit running disparity.
`timescale 1ns/1ps
module char_encoder (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [7:0] byte_in,
    input wire logic is_ctrl,
    input wire logic is_comma,
    output logic [9:0] code,
    output logic rd
);
    import char_codec_pkg::*;

    logic [5:0] c6;
    logic [3:0] c4;
    logic [2:0] y;
    logic rd_mid;
    logic rd_end;

    always_comb begin
        y = is_ctrl ? (is_comma ? K_Y_SYNC : K_Y_PRIM) : byte_in[7:5];
        c6 = is_ctrl ? (rd ? ~K6_NEG : K6_NEG) : enc6(byte_in[4:0], rd); // R1 R2 R4
        rd_mid = rd_step(rd, c6, HALF6); // R14
        c4 = enc4(y, rd_mid, c6[1], c6[0]);
        // A control half follows the disparity at the start of the character, not the mid one.
        if (is_ctrl && is_comma) begin
            c4 = rd ? K285_POS[3:0] : K285_NEG[3:0]; // R2
        end else if (is_ctrl) begin
            c4 = rd ? K283_POS[3:0] : K283_NEG[3:0]; // R1
        end
        rd_end = rd_step(rd_mid, {2'h0, c4}, HALF4); // R5
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            code <= 10'h000;
            rd <= RD_INIT;
        end else if (load) begin
            code <= {c6, c4};
            rd <= rd_end;
        end
    end

endmodule

// ### logic/char_decoder.sv
// Registered 8b/10b character decoder with code violation check and disparity tracking.
`timescale 1ns/1ps
module char_decoder (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic go,
    input wire logic [9:0] code,
    output logic [7:0] data,
    output logic ctrl,
    output logic viol,
    output logic valid,
    output logic rd
);
    import char_codec_pkg::*;

    logic [4:0] x;
    logic [2:0] y;
    logic hit6;
    logic hit4;
    logic is_k;
    logic rd_mid;
    logic rd_end;
    logic ok;

    // Searching only the current disparity column also rejects repeated sign.
    always_comb begin
        x = 5'h00;
        y = 3'h0;
        hit6 = 1'b0;
        hit4 = 1'b0;
        is_k = code[9:4] == (rd ? ~K6_NEG : K6_NEG);
        for (int n = 0; n < 32; n++) begin
            if (enc6(5'(n), rd) == code[9:4]) begin // R11
                hit6 = 1'b1;
                x = 5'(n);
            end
        end
        if (is_k) begin
            hit6 = 1'b1;
            x = K_X;
        end
        rd_mid = rd_step(rd, code[9:4], HALF6); // R14
        for (int n = 0; n < 8; n++) begin
            if (enc4(3'(n), rd_mid, code[5], code[4]) == code[3:0]) begin
                hit4 = 1'b1;
                y = 3'(n);
            end
        end
        // Control halves are looked up by the starting disparity, as the encoder makes them.
        if (is_k) begin
            hit4 = 1'b0;
            if (code[3:0] == (rd ? K283_POS[3:0] : K283_NEG[3:0])) begin // R3
                hit4 = 1'b1;
                y = K_Y_PRIM;
            end
            if (code[3:0] == (rd ? K285_POS[3:0] : K285_NEG[3:0])) begin // R3
                hit4 = 1'b1;
                y = K_Y_SYNC;
            end
        end
        rd_end = rd_step(rd_mid, {2'h0, code[3:0]}, HALF4);
        ok = hit6 && hit4 && (!is_k || (y == K_Y_PRIM) || (y == K_Y_SYNC)); // R3 R12 R15
    end

    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            data <= 8'h00;
            ctrl <= 1'b0;
            viol <= 1'b0;
            valid <= 1'b0;
            rd <= RD_INIT;
        end else begin
            valid <= go;
            if (go) begin
                data <= {y, x};
                ctrl <= is_k; // R18
                viol <= !ok; // R12
                rd <= rd_end; // R13
            end
        end
    end

endmodule

// ### bench/serial_node_model.sv
// Remote serial node: makes the link clock, sends code groups and captures the transmit stream.
`timescale 1ns/1ps
module serial_node_model (
    input wire logic run,
    input wire logic ser_tx,
    output logic link_clk,
    output logic ser_rx
);
    import char_codec_pkg::*;
    logic [9:0] send_q[$];
    logic [9:0] got_q[$];
    logic [9:0] out_r;
    logic [9:0] in_r;
    int out_n;
    int in_n;
    logic locked;

    initial begin
        link_clk = 1'h0;
        ser_rx = 1'h0;
        out_r = 10'h000;
        in_r = 10'h000;
        out_n = 0;
        in_n = 0;
        locked = 1'h0;
    end

    // The clock stands still while no traffic is wanted.
    always begin
        #40;
        link_clk = run ? ~link_clk : 1'h0;
    end

    // Bit a leaves first; an empty queue gives alternating bits, a legal neutral idle stream.
    always @(negedge link_clk) begin
        if (out_n == 0 && send_q.size() > 0) begin
            out_r = send_q.pop_front();
            out_n = 10;
        end
        if (out_n > 0) begin
            ser_rx = out_r[9];
            out_r = out_r << 1;
            out_n = out_n - 1;
        end else begin
            ser_rx = ~ser_rx;
        end
    end

    // Mid-bit sampling; the comma character sets the character boundary.
    always @(negedge link_clk) begin
        in_r = {in_r[8:0], ser_tx};
        if (locked) begin
            in_n = in_n + 1;
            if (in_n == 10) begin
                got_q.push_back(in_r);
                in_n = 0;
            end
        end else if (in_r == K285_NEG || in_r == K285_POS) begin
            locked = 1'h1;
            got_q.push_back(in_r);
            in_n = 0;
        end
    end
endmodule

// ### bench/tb_top.sv
// Self-checking bench for the character codec against a remote serial node model.
`timescale 1ns/1ps
module tb_top;
    import char_codec_pkg::*;
    logic core_clk = 1'h0;
    logic rst_n = 1'h0;
    logic [31:0] tx_dword = 32'h0;
    logic tx_prim = 1'h0;
    logic tx_sync = 1'h0;
    logic tx_valid = 1'h0;
    logic err_clr = 1'h0;
    logic run = 1'h0;
    logic tx_ready, link_clk, ser_tx, ser_rx, rx_ctrl, rx_valid, rx_viol, rx_misplaced;
    logic [7:0] rx_byte;
    logic [1:0] rx_lane;
    logic [ERR_W-1:0] err_count;
    logic [31:0] seed = 32'h7668;
    logic tx_rd = RD_INIT;
    logic rx_rd = RD_INIT;
    logic [9:0] exp_tx[$];
    logic [12:0] exp_rx[$];
    int miscompares = 0;
    int tests_run = 0;

    always #4 core_clk = ~core_clk;

    serial_8b10b_char_codec dut (.core_clk(core_clk), .rst_n(rst_n), .tx_dword(tx_dword),
        .tx_prim(tx_prim), .tx_sync(tx_sync), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .link_clk(link_clk), .ser_tx(ser_tx), .ser_rx(ser_rx), .rx_byte(rx_byte),
        .rx_ctrl(rx_ctrl), .rx_lane(rx_lane), .rx_valid(rx_valid), .rx_viol(rx_viol),
        .rx_misplaced(rx_misplaced), .err_count(err_count), .err_clr(err_clr));

    serial_node_model node (.run(run), .ser_tx(ser_tx), .link_clk(link_clk), .ser_rx(ser_rx));

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Sub-block disparity is carried from the six-bit part into the four-bit part.
    function automatic logic [9:0] enc(input logic [7:0] b, input logic k, inout logic rd);
        logic [5:0] c6;
        logic [3:0] c4;
        logic [9:0] kc;
        if (k) begin
            kc = (b == 8'hBC) ? (rd ? K285_POS : K285_NEG) : (rd ? K283_POS : K283_NEG);
            rd = ~rd;
            return kc;
        end
        c6 = TAB6[b[4:0]];
        if (rd && ($countones(c6) != 3 || b[4:0] == 5'h07)) c6 = ~c6;
        if ($countones(c6) != 3) rd = ($countones(c6) > 3);
        c4 = TAB4[b[7:5]];
        if (b[7:5] == 3'h7 && ((!rd && c6[1] && c6[0]) || (rd && !c6[1] && !c6[0]))) c4 = ALT7;
        if (rd && ($countones(c4) != 2 || b[7:5] == 3'h3)) c4 = ~c4;
        if ($countones(c4) != 2) rd = ($countones(c4) > 2);
        return {c6, c4};
    endfunction

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (exp !== got) begin
            $display("[ERR] %s expected %h seen %h", name, exp, got);
            miscompares++;
        end
    endtask

    task automatic stop_test();
        if (miscompares == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Queues one received character: raw code and what the decoder must report.
    task automatic rx_put(input logic [9:0] c, input logic [7:0] b, input logic k,
                          input logic [1:0] ln, input logic v, input logic full);
        node.send_q.push_back(c);
        exp_rx.push_back({full, v, k, ln, b});
    endtask

    task automatic rx_dw(input logic [31:0] d, input logic p);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            b = (p && i == 0) ? ((d[7:0] == 8'hBC) ? 8'hBC : 8'h7C) : d[8*i +: 8];
            rx_put(enc(b, p && i == 0, rx_rd), b, p && i == 0, 2'(i), 1'h0, 1'h1);
        end
    endtask

    task automatic tx_dw(input logic [31:0] d, input logic p, input logic s);
        int n;
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            b = (p && i == 0) ? (s ? 8'hBC : 8'h7C) : d[8*i +: 8];
            exp_tx.push_back(enc(b, p && i == 0, tx_rd));
        end
        tx_dword <= d;
        tx_prim <= p;
        tx_sync <= s;
        tx_valid <= 1'h1;
        n = 0;
        while (tx_ready !== 1'h1 && n < 2000) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 2000) chk("tx_ready", 16'h1, 16'(tx_ready));
        @(negedge core_clk);
    endtask

    // Decoded characters are compared as they appear; idle characters after the list are ignored.
    always @(negedge core_clk) begin
        logic [12:0] e;
        if (rx_valid === 1'h1 && exp_rx.size() > 0) begin
            e = exp_rx.pop_front();
            chk("rx_viol", 16'(e[11]), 16'(rx_viol));
            chk("rx_misplaced", 16'h0, 16'(rx_misplaced));
            if (e[12]) begin
                chk("rx_byte", 16'(e[7:0]), 16'(rx_byte));
                chk("rx_ctrl", 16'(e[10]), 16'(rx_ctrl));
                chk("rx_lane", 16'(e[9:8]), 16'(rx_lane));
            end
        end
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        miscompares++;
        stop_test();
    end

    initial begin
        logic [31:0] r;
        int n;
        // Receive list: lane-sync, then a single-bit error that decodes cleanly as D21.0 and shows as a violation two characters later.
        rx_dw(32'h7B4A4ABC, 1'h1);
        rx_put(10'h2AB, 8'h15, 1'h0, 2'h0, 1'h0, 1'h1);
        rx_put(10'h155, 8'h4A, 1'h0, 2'h1, 1'h0, 1'h1);
        rx_put(10'h3AA, 8'h00, 1'h0, 2'h2, 1'h1, 1'h0);
        rx_rd = 1'h1;
        r = xs();
        rx_put(enc(r[7:0], 1'h0, rx_rd), r[7:0], 1'h0, 2'h3, 1'h0, 1'h1);
        for (int i = 0; i < 8; i++) begin
            r = xs();
            rx_dw(xs(), r[1:0] == 2'h0);
        end
        repeat (10) @(negedge core_clk);
        rst_n = 1'h1;
        run = 1'h1;
        // Transmit: lane-sync, a frame of SOF, payload, CRC, EOF, a second sync, random traffic.
        for (int i = 0; i < 12; i++) begin
            r = xs();
            if (i == 0 || i == 7) tx_dw(32'h7B4A4A00, 1'h1, 1'h1);
            else if (i == 1 || i == 6) tx_dw(xs(), 1'h1, 1'h0);
            else tx_dw(xs(), r[1:0] == 2'h0, 1'h0);
        end
        tx_valid <= 1'h0;
        n = 0;
        while ((node.got_q.size() < exp_tx.size() || exp_rx.size() > 0) && n < 30000) begin
            @(negedge core_clk);
            n++;
        end
        n = (node.got_q.size() < exp_tx.size()) ? 0 : exp_tx.size();
        chk("tx_chars", 16'(exp_tx.size()), 16'(n));
        chk("rx_left", 16'h0, 16'(exp_rx.size()));
        for (int i = 0; i < exp_tx.size() && i < node.got_q.size(); i++) begin
            chk("tx_code", 16'(exp_tx[i]), 16'(node.got_q[i]));
        end
        repeat (4) @(negedge core_clk);
        chk("err_count", 16'h0001, 16'(err_count));
        err_clr <= 1'h1;
        @(negedge core_clk);
        err_clr <= 1'h0;
        repeat (2) @(negedge core_clk);
        chk("err_clear", 16'h0000, 16'(err_count));
        stop_test();
    end
endmodule
